// ---- include/pbcap_consts.svh ----
`ifndef PBCAP_CONSTS_SVH
`define PBCAP_CONSTS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define PBCAP_OFS_HEADER 12'h138
`define PBCAP_OFS_INDEX 12'h13C
`define PBCAP_OFS_WINDOW 12'h140
`define PBCAP_OFS_FLAGS 12'h144

// ------------------------------------------------------------
// Field layout and reset values
// ------------------------------------------------------------
`define PBCAP_ENTRY_W 21
`define PBCAP_NUM_ENTRIES 8
`define PBCAP_HDR_RESET 32'h1481_0004
`define PBCAP_INDEX_RESET 8'h00
`define PBCAP_ENTRY_RESET 21'h00_0000
`define PBCAP_SYSALLOC_RESET 1'b1
`define PBCAP_BASE_LSB 0
`define PBCAP_SCALE_LSB 8
`define PBCAP_SUBST_LSB 10
`define PBCAP_PSTATE_LSB 13
`define PBCAP_TYPE_LSB 15
`define PBCAP_RAIL_LSB 18
`endif

// ---- include/pbcap_pkg.sv ----
package pbcap_pkg;
  typedef enum logic [1:0] {
    PBCAP_SCALE_1 = 2'b00,
    PBCAP_SCALE_0P1 = 2'b01,
    PBCAP_SCALE_0P01 = 2'b10,
    PBCAP_SCALE_0P001 = 2'b11
  } pbcap_scale_t;
  typedef enum logic [1:0] {
    PBCAP_PS_D0 = 2'b00,
    PBCAP_PS_D3 = 2'b11
  } pbcap_pstate_t;
  typedef enum logic [2:0] {
    PBCAP_TY_PME_AUX = 3'b000,
    PBCAP_TY_AUX = 3'b001,
    PBCAP_TY_IDLE = 3'b010,
    PBCAP_TY_SUSTAINED = 3'b011,
    PBCAP_TY_MAXIMUM = 3'b111
  } pbcap_type_t;
  typedef enum logic [2:0] {
    PBCAP_RAIL_12V = 3'b000,
    PBCAP_RAIL_3V3 = 3'b001,
    PBCAP_RAIL_1V8 = 3'b010,
    PBCAP_RAIL_THERMAL = 3'b111
  } pbcap_rail_t;
  typedef enum logic [1:0] {
    PBCAP_R_HEADER = 2'b00,
    PBCAP_R_INDEX = 2'b01,
    PBCAP_R_WINDOW = 2'b10,
    PBCAP_R_FLAGS = 2'b11
  } pbcap_reg_t;
endpackage

// ---- verilog/pbcap_entry_store.sv ----
`include "pbcap_consts.svh"
// Array of budget entries, written only by the loader path
module pbcap_entry_store #(
  parameter int ENTRIES = `PBCAP_NUM_ENTRIES,
  parameter int ENTRY_W = `PBCAP_ENTRY_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_idx_i,
  input wire logic [ENTRY_W-1:0] wr_data_i,
  input wire logic [7:0] rd_idx_i,
  output logic [ENTRY_W-1:0] rd_data_o
);
  logic [ENTRY_W-1:0] mem_q [ENTRIES];

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  for (genvar g = 0; g < ENTRIES; g++) begin : g_entry
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        mem_q[g] <= `PBCAP_ENTRY_RESET;
      end else if (wr_en_i && wr_idx_i == 8'(g)) begin
        mem_q[g] <= wr_data_i;
      end
    end
  end

  // Out-of-range index yields zero rather than aliasing
  always_comb begin
    rd_data_o = '0;
    if (rd_idx_i < 8'(ENTRIES)) begin
      rd_data_o = mem_q[rd_idx_i[$clog2(ENTRIES)-1:0]];
    end
  end
endmodule // pbcap_entry_store

// ---- verilog/pbcap_entry_fmt.sv ----
`include "pbcap_consts.svh"
// Places entry fields into the 32-bit window word
module pbcap_entry_fmt
  import pbcap_pkg::*;
#(
  parameter int ENTRY_W = `PBCAP_ENTRY_W
) (
  input wire logic [ENTRY_W-1:0] entry_i,
  output logic [31:0] word_o,
  output pbcap_pkg::pbcap_scale_t scale_o,
  output pbcap_pkg::pbcap_pstate_t pstate_o,
  output pbcap_pkg::pbcap_type_t type_o,
  output pbcap_pkg::pbcap_rail_t rail_o
);
  logic [2:0] pm_substate_code;
  // Fields placed one by one so bits 31:21 can only ever read zero
  assign word_o = {
    11'h000,
    entry_i[`PBCAP_RAIL_LSB +: 3],
    entry_i[`PBCAP_TYPE_LSB +: 3],
    entry_i[`PBCAP_PSTATE_LSB +: 2],
    pm_substate_code,
    entry_i[`PBCAP_SCALE_LSB +: 2],
    entry_i[`PBCAP_BASE_LSB +: 8]
  };
  assign scale_o = pbcap_scale_t'(entry_i[`PBCAP_SCALE_LSB +: 2]);
  assign pm_substate_code = entry_i[`PBCAP_SUBST_LSB +: 3];
  assign pstate_o = pbcap_pstate_t'(entry_i[`PBCAP_PSTATE_LSB +: 2]);
  assign type_o = pbcap_type_t'(entry_i[`PBCAP_TYPE_LSB +: 3]);
  assign rail_o = pbcap_rail_t'(entry_i[`PBCAP_RAIL_LSB +: 3]);
endmodule // pbcap_entry_fmt

// ---- verilog/pbcap_regs.sv ----
`include "pbcap_consts.svh"
// Power budget extended capability register bank
module pbcap_regs #(
  parameter int ENTRIES = `PBCAP_NUM_ENTRIES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic upstream_i,
  // Configuration access from software
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // Loader path (serial EEPROM, I2C, SMBus)
  input wire logic ld_wr_i,
  input wire logic [11:0] ld_addr_i,
  input wire logic [31:0] ld_wdata_i,
  // Decoded view of the selected entry
  output pbcap_pkg::pbcap_scale_t sel_scale_o,
  output pbcap_pkg::pbcap_pstate_t sel_pstate_o,
  output pbcap_pkg::pbcap_type_t sel_type_o,
  output pbcap_pkg::pbcap_rail_t sel_rail_o
);
  import pbcap_pkg::*;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic [2:0] dec(input logic [11:0] a);
    case (a)
      `PBCAP_OFS_HEADER: dec = {1'b1, PBCAP_R_HEADER};
      `PBCAP_OFS_INDEX: dec = {1'b1, PBCAP_R_INDEX};
      `PBCAP_OFS_WINDOW: dec = {1'b1, PBCAP_R_WINDOW};
      `PBCAP_OFS_FLAGS: dec = {1'b1, PBCAP_R_FLAGS};
      default: dec = 3'b000;
    endcase
  endfunction

  // Both access paths share one decoder, so the hit test is shared too
  function automatic logic hit(input logic [2:0] d, input pbcap_reg_t r);
    hit = d == {1'b1, r};
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam logic [31:0] HDR_RESET = `PBCAP_HDR_RESET;

  logic [2:0] cfg_dec;
  logic [2:0] ld_dec;
  logic ld_hdr_hit;
  logic ld_idx_hit;
  logic ld_win_hit;
  logic ld_flg_hit;
  logic cfg_idx_hit;
  logic [15:0] cap_id_q;
  logic [15:0] cap_id_d;
  logic [3:0] cap_ver_q;
  logic [3:0] cap_ver_d;
  logic [11:0] next_ptr_q;
  logic [11:0] next_ptr_d;
  logic [7:0] index_q;
  logic [7:0] index_d;
  logic sysalloc_q;
  logic sysalloc_d;
  logic [`PBCAP_ENTRY_W-1:0] entry;
  logic [31:0] window;
  logic [31:0] rdata_d;
  logic ld_entry_wr;
  logic in_range;
  pbcap_scale_t scale;
  pbcap_pstate_t pstate;
  pbcap_type_t ptype;
  pbcap_rail_t rail;
  pbcap_scale_t scale_d;
  pbcap_pstate_t pstate_d;
  pbcap_type_t ptype_d;
  pbcap_rail_t rail_d;

  // ------------------------------------------------------------
  // Write hits
  // ------------------------------------------------------------
  // Software may only move the index; every other software write is
  // decoded but deliberately has no target.
  assign cfg_dec = dec(cfg_addr_i);
  assign ld_dec = dec(ld_addr_i);
  assign ld_hdr_hit = ld_wr_i && hit(ld_dec, PBCAP_R_HEADER);
  assign ld_idx_hit = ld_wr_i && hit(ld_dec, PBCAP_R_INDEX);
  assign ld_win_hit = ld_wr_i && hit(ld_dec, PBCAP_R_WINDOW);
  assign ld_flg_hit = ld_wr_i && hit(ld_dec, PBCAP_R_FLAGS);
  assign cfg_idx_hit = cfg_wr_i && hit(cfg_dec, PBCAP_R_INDEX);
  assign ld_entry_wr = ld_win_hit;
  assign in_range = index_q < 8'(ENTRIES);

  // ------------------------------------------------------------
  // Index register: software or loader may write it
  // ------------------------------------------------------------
  // The loader wins a same-cycle clash, so an image still being
  // replayed cannot be knocked off its entry by a software write in that cycle.
  always_comb begin
    index_d = index_q;
    if (ld_idx_hit) begin
      index_d = ld_wdata_i[7:0];
    end else if (cfg_idx_hit) begin
      index_d = cfg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      index_q <= `PBCAP_INDEX_RESET;
    end else begin
      index_q <= index_d;
    end
  end

  // ------------------------------------------------------------
  // Capability header: read-only to software, loadable as a dword
  // ------------------------------------------------------------
  // Kept as three fields so a partial image only needs one dword write,
  // and the reset value stays in one constant.
  always_comb begin
    cap_id_d = cap_id_q;
    cap_ver_d = cap_ver_q;
    next_ptr_d = next_ptr_q;
    if (ld_hdr_hit) begin
      cap_id_d = ld_wdata_i[15:0];
      cap_ver_d = ld_wdata_i[19:16];
      next_ptr_d = ld_wdata_i[31:20];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cap_id_q <= HDR_RESET[15:0];
    end else begin
      cap_id_q <= cap_id_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cap_ver_q <= HDR_RESET[19:16];
    end else begin
      cap_ver_q <= cap_ver_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      next_ptr_q <= HDR_RESET[31:20];
    end else begin
      next_ptr_q <= next_ptr_d;
    end
  end

  // ------------------------------------------------------------
  // Allocation flag: hardware-initialised, only the loader changes it
  // ------------------------------------------------------------
  always_comb begin
    sysalloc_d = sysalloc_q;
    if (ld_flg_hit) begin
      sysalloc_d = ld_wdata_i[0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sysalloc_q <= `PBCAP_SYSALLOC_RESET;
    end else begin
      sysalloc_q <= sysalloc_d;
    end
  end

  // ------------------------------------------------------------
  // Entry storage and formatting
  // ------------------------------------------------------------
  // The loader writes land at the entry the index names, so it must
  // set the index first; software writes to the window are dropped.
  pbcap_entry_store #(
    .ENTRIES(ENTRIES),
    .ENTRY_W(`PBCAP_ENTRY_W)
  ) u_store (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .wr_en_i(ld_entry_wr),
    .wr_idx_i(index_q),
    .wr_data_i(ld_wdata_i[`PBCAP_ENTRY_W-1:0]),
    .rd_idx_i(index_q),
    .rd_data_o(entry)
  );

  pbcap_entry_fmt #(
    .ENTRY_W(`PBCAP_ENTRY_W)
  ) u_fmt (
    .entry_i(entry),
    .word_o(window),
    .scale_o(scale),
    .pstate_o(pstate),
    .type_o(ptype),
    .rail_o(rail)
  );

  // ------------------------------------------------------------
  // Read mux; downstream ports hide the whole structure
  // ------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (upstream_i && cfg_dec[2]) begin
      case (pbcap_reg_t'(cfg_dec[1:0]))
        PBCAP_R_HEADER: rdata_d = {next_ptr_q, cap_ver_q, cap_id_q};
        PBCAP_R_INDEX: rdata_d = {24'h00_0000, index_q};
        PBCAP_R_WINDOW: rdata_d = window;
        PBCAP_R_FLAGS: rdata_d = {31'h0000_0000, sysalloc_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read answer
  // ------------------------------------------------------------
  // Data is zeroed between reads so a stale word is never taken for
  // an answer; the cost is one more mux in front of the flops.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_rdata_o <= 32'h0000_0000;
    end else if (cfg_rd_i) begin
      cfg_rdata_o <= rdata_d;
    end else begin
      cfg_rdata_o <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
    end
  end

  // ------------------------------------------------------------
  // Field view of the selected entry
  // ------------------------------------------------------------
  // Registered for the power management logic; an index outside the
  // table shows the reset codes rather than an aliased entry.
  always_comb begin
    scale_d = PBCAP_SCALE_1;
    pstate_d = PBCAP_PS_D0;
    ptype_d = PBCAP_TY_PME_AUX;
    rail_d = PBCAP_RAIL_12V;
    if (in_range) begin
      scale_d = scale;
      pstate_d = pstate;
      ptype_d = ptype;
      rail_d = rail;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sel_scale_o <= PBCAP_SCALE_1;
    end else begin
      sel_scale_o <= scale_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sel_pstate_o <= PBCAP_PS_D0;
    end else begin
      sel_pstate_o <= pstate_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sel_type_o <= PBCAP_TY_PME_AUX;
    end else begin
      sel_type_o <= ptype_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sel_rail_o <= PBCAP_RAIL_12V;
    end else begin
      sel_rail_o <= rail_d;
    end
  end
endmodule // pbcap_regs

// ---- verif/pbcap_regs_props.sv ----
module pbcap_regs_props
  import pbcap_pkg::*;
#(
  parameter int ENTRIES = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic upstream_i,
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic cfg_rvalid_o,
  input wire logic ld_wr_i,
  input wire logic [11:0] ld_addr_i,
  input wire logic [31:0] ld_wdata_i,
  input wire pbcap_pkg::pbcap_scale_t sel_scale_o,
  input wire pbcap_pkg::pbcap_pstate_t sel_pstate_o,
  input wire pbcap_pkg::pbcap_type_t sel_type_o,
  input wire pbcap_pkg::pbcap_rail_t sel_rail_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] idx_q;
  logic rd_win;
  assign rd_win = cfg_rd_i && cfg_addr_i == 12'h140;
  // Shadow index; the loader wins a same-cycle clash
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      idx_q <= 8'h00;
    end else if (ld_wr_i && ld_addr_i == 12'h13C) begin
      idx_q <= ld_wdata_i[7:0];
    end else if (cfg_wr_i && cfg_addr_i == 12'h13C) begin
      idx_q <= cfg_wdata_i[7:0];
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  a_down_reads_zero: assert property (!upstream_i && cfg_rd_i |=> cfg_rdata_o == 32'h0)
    else $error("downstream read not zero");
  a_read_answer: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("read without answer");
  a_index_top_zero: assert property (cfg_rd_i && cfg_addr_i == 12'h13C |=> cfg_rdata_o[31:8] == 24'h0)
    else $error("index upper bits set");
  a_window_top_zero: assert property (rd_win |=> cfg_rdata_o[31:21] == 11'h0)
    else $error("window upper bits set");
  a_flags_top_zero: assert property (cfg_rd_i && cfg_addr_i == 12'h144 |=> cfg_rdata_o[31:1] == 31'h0)
    else $error("flags upper bits set");
  a_high_index_read: assert property (rd_win && idx_q >= ENTRIES |=> cfg_rdata_o == 32'h0)
    else $error("window not zero for index above range");
  a_high_index_fields: assert property (idx_q >= ENTRIES && $stable(idx_q) |-> sel_scale_o == PBCAP_SCALE_1 && sel_rail_o == PBCAP_RAIL_12V && sel_type_o == PBCAP_TY_PME_AUX)
    else $error("decoded fields not zero for index above range");
  a_fields_match: assert property (upstream_i && rd_win |=> cfg_rdata_o[20:8] == {sel_rail_o, sel_type_o, sel_pstate_o, cfg_rdata_o[12:10], sel_scale_o})
    else $error("decoded fields differ from window");
  c_high_index: cover property (rd_win && idx_q >= ENTRIES);
  c_loader_window: cover property (ld_wr_i && ld_addr_i == 12'h140);
  c_down_read: cover property (!upstream_i && cfg_rd_i);
endmodule // pbcap_regs_props
bind pbcap_regs pbcap_regs_props #(.ENTRIES(ENTRIES)) u_props (.*);

// ---- verif/pbcap_loader_model.sv ----
module pbcap_loader_model (
  input wire logic clk_sys_i,
  output logic ld_wr_o,
  output logic [11:0] ld_addr_o,
  output logic [31:0] ld_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ld_wr_o = 1'b0;
    ld_addr_o = 12'h000;
    ld_wdata_o = 32'h0;
  end
  // Released lines flip so a stale value is never mistaken for a write
  task automatic put(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    ld_wr_o <= 1'b1;
    ld_addr_o <= a;
    ld_wdata_o <= d;
    @(posedge clk_sys_i);
    ld_wr_o <= 1'b0;
    ld_addr_o <= ~a;
    ld_wdata_o <= ~d;
  endtask
  task automatic load_entry(input logic [7:0] i, input logic [31:0] d);
    put(12'h13C, {24'h0, i});
    put(12'h140, d);
  endtask
endmodule // pbcap_loader_model

// ---- verif/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pbcap_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic upstream_i = 1'b1;
  logic cfg_rd_i = 1'b0;
  logic cfg_wr_i = 1'b0;
  logic [11:0] cfg_addr_i = 12'h000;
  logic [31:0] cfg_wdata_i = 32'h0;
  logic [31:0] cfg_rdata_o;
  logic cfg_rvalid_o;
  logic ld_wr_i;
  logic [11:0] ld_addr_i;
  logic [31:0] ld_wdata_i;
  pbcap_scale_t sel_scale_o;
  pbcap_pstate_t sel_pstate_o;
  pbcap_type_t sel_type_o;
  pbcap_rail_t sel_rail_o;
  int fails = 0;
  int samples_checked = 0;
  int m_idx = 0;
  logic [31:0] m_ent [8] = '{default: 32'h0};
  logic [31:0] rnd = 32'h11;
  logic [31:0] v;
  pbcap_regs dut (.*);
  pbcap_loader_model ldr (.clk_sys_i(clk_sys_i), .ld_wr_o(ld_wr_i), .ld_addr_o(ld_addr_i),
    .ld_wdata_o(ld_wdata_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    cfg_wr_i <= 1'b1;
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    @(posedge clk_sys_i);
    cfg_wr_i <= 1'b0;
    if (a == 12'h13C) m_idx = d[7:0];
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    int n;
    @(posedge clk_sys_i);
    cfg_rd_i <= 1'b1;
    cfg_addr_i <= a;
    @(posedge clk_sys_i);
    cfg_rd_i <= 1'b0;
    #1;
    for (n = 0; n < 4 && cfg_rvalid_o !== 1'b1; n++) @(posedge clk_sys_i) #1;
    if (n == 4) begin
      fails++;
      wrap_up();
    end
    q = cfg_rdata_o;
  endtask
  task automatic chk_win();
    logic [31:0] e;
    e = (m_idx < 8) ? m_ent[m_idx] & 32'h001F_FFFF : 32'h0;
    rd(12'h140, v);
    chk(v, e);
    chk({11'h0, sel_rail_o, sel_type_o, sel_pstate_o, 3'h0, sel_scale_o, 8'h0}, e & 32'h001F_E300);
  endtask
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(12'h138, v);
    chk(v, 32'h1481_0004);
    rd(12'h13C, v);
    chk(v, 32'h0);
    chk_win();
    rd(12'h144, v);
    chk(v, 32'h1);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      m_ent[i] = rnd;
      ldr.load_entry(i[7:0], rnd);
    end
    for (int i = 7; i >= 0; i--) begin
      wr(12'h13C, i);
      chk_win();
      rd(12'h13C, v);
      chk(v, i);
    end
    // Every field code walked through entry zero
    for (int c = 0; c < 8; c++) begin
      m_ent[0] = {11'h0, c[2:0], c[2:0], c[1:0], c[2:0], c[1:0], 5'h0, c[2:0]};
      ldr.load_entry(8'h00, m_ent[0]);
      chk_win();
    end
    wr(12'h13C, 8);
    chk_win();
    wr(12'h13C, 32'hFF);
    chk_win();
    ldr.load_entry(8'h09, lfsr(rnd));
    m_idx = 9;
    chk_win();
    wr(12'h13C, 0);
    chk_win();
    for (int a = 12'h138; a <= 12'h148; a += 4) wr(a[11:0], lfsr(rnd ^ a));
    m_idx = 32'h00FF & (lfsr(rnd ^ 32'h13C));
    rd(12'h138, v);
    chk(v, 32'h1481_0004);
    rd(12'h148, v);
    chk(v, 32'h0);
    wr(12'h13C, 1);
    chk_win();
    ldr.put(12'h144, 32'h0);
    rd(12'h144, v);
    chk(v, 32'h0);
    ldr.put(12'h138, rnd);
    rd(12'h138, v);
    chk(v, rnd);
    @(posedge clk_sys_i);
    upstream_i <= 1'b0;
    for (int a = 12'h138; a <= 12'h144; a += 4) begin
      rd(a[11:0], v);
      chk(v, 32'h0);
    end
    wrap_up();
  end
endmodule // testbench
